// *** inc/wdta_defs.vh ***
/*
 * constants for the watchdog with timed-access protection: special
 * function register addresses, field positions, reset values, unlock keys
 * and timing counts.
 * assumes it is included by bare name from every design file that needs it.
 */
`ifndef WDTA_DEFS_VH
`define WDTA_DEFS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define WDTA_ADDR_CLOCK_CONTROL 8'h8e
`define WDTA_ADDR_EXT_IRQ_FLAG 8'h91
`define WDTA_ADDR_ROM_SIZE 8'hc2
`define WDTA_ADDR_TA_UNLOCK 8'hc7
`define WDTA_ADDR_WATCHDOG_CONTROL 8'hd8
`define WDTA_ADDR_EXT_IRQ_ENABLE 8'he8

// ****************************************************************
// field positions
// ****************************************************************
`define WDTA_BIT_SEL_HI 7
`define WDTA_BIT_SEL_LO 6
`define WDTA_BIT_POR_FLAG 6
`define WDTA_BIT_PFI_EN 5
`define WDTA_BIT_PFI_FLAG 4
`define WDTA_BIT_IRQ_FLAG 3
`define WDTA_BIT_RESET_FLAG 2
`define WDTA_BIT_RESET_EN 1
`define WDTA_BIT_RESTART 0
`define WDTA_BIT_IRQ_EN 4
`define WDTA_BIT_BANDGAP 0

// ****************************************************************
// reset values
// ****************************************************************
`define WDTA_RST_CLOCK_CONTROL 8'h00
`define WDTA_RST_EXT_IRQ_ENABLE 8'h00
`define WDTA_RST_ROM_SIZE 3'h5
`define WDTA_RST_RESET_EN 1'h0

// ****************************************************************
// unlock keys, timing, interrupt vector and priority
// ****************************************************************
`define WDTA_KEY_FIRST 8'haa
`define WDTA_KEY_SECOND 8'h55
`define WDTA_WINDOW_CYCLES 2'h3
`define WDTA_GRACE_CLOCKS 10'h200
`define WDTA_IRQ_VECTOR 8'h63
`define WDTA_IRQ_PRIORITY 4'hd

`endif

// *** src/wdta_unlock.v ***
/*
 * timed-access unlock tracker: watches writes to the unlock register and
 * opens a short window in which protected bits may be written.
 * assumes write strobes are one-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
`include "wdta_defs.vh"

module wdta_unlock #(
    parameter WINDOW = `WDTA_WINDOW_CYCLES
) (
    input wire clock,
    input wire reset,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    output wire window_open
);

    // ****************************************************************
    // key sequence state
    // ****************************************************************
    reg first_seen; // first key written, second awaited
    reg [1:0] window_left; // cycles of open window remaining

    wire unlock_wr = wr_en && (wr_addr == `WDTA_ADDR_TA_UNLOCK);

    // first key, then second key as the next write, opens the window
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            first_seen <= 1'b0;
            window_left <= 2'h0;
        end else begin
            if (unlock_wr) begin
                // any other write to the unlock register breaks the sequence
                first_seen <= (wr_data == `WDTA_KEY_FIRST);
            end else if (wr_en) begin
                // an unrelated write between keys spoils it
                first_seen <= 1'b0;
            end
            if (unlock_wr && first_seen && wr_data == `WDTA_KEY_SECOND) begin
                window_left <= WINDOW[1:0];
            end else if (window_left != 2'h0) begin
                window_left <= window_left - 2'h1;
            end
        end
    end

    assign window_open = (window_left != 2'h0);

endmodule

// *** src/wdta_watchdog.v ***
/*
 * watchdog timer with timed-access protected controls, reached through
 * special function register write and read ports of the processor.
 * assumes one crystal clock; writes are one-cycle strobes; reads are
 * combinational address decodes with registered data in the same cycle.
 */
`timescale 1ns/100ps
`include "wdta_defs.vh"

module wdta_watchdog #(
    parameter CNT_W = 26,
    parameter GRACE = `WDTA_GRACE_CLOCKS
) (
    input wire clock,
    input wire reset,
    input wire sfr_wr,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output wire sfr_hit,
    input wire por_event,
    input wire pfi_event,
    input wire power_saving,
    output wire wdog_timeout_irq,
    output wire [7:0] irq_vector,
    output wire [3:0] irq_priority,
    output wire wake_request,
    output reg cpu_reset,
    output wire bandgap_select,
    output wire [2:0] rom_size_sel
);

    // ****************************************************************
    // storage
    // ****************************************************************
    reg [7:0] clock_control; // bits 7:6 timeout select, rest plain storage
    reg [7:0] extended_interrupt_enable; // bit 4 is the watchdog irq enable
    reg por_flag; // power-on reset flag
    reg pfi_en; // power-fail interrupt enable, plain storage
    reg pfi_flag; // power-fail flag, hardware set
    reg wdog_irq_flag;
    reg wdog_reset_flag;
    reg wdog_reset_en;
    reg bg_sel; // bandgap select
    reg [2:0] rom_size; // rom size select
    reg [CNT_W-1:0] wdog_count; // main interval counter
    reg [9:0] grace_count; // clocks since interrupt flag
    reg grace_run; // interval done, grace period running
    // the power events come from outside the clock domain, so they pass two
    // flops before the flag logic; a pulse shorter than a clock may be lost
    reg [1:0] sync_por; // two-flop sync of external flag pulses
    reg [1:0] sync_pfi;

    wire window_open;
    wire timeout_select_hi = clock_control[`WDTA_BIT_SEL_HI];
    wire timeout_select_lo = clock_control[`WDTA_BIT_SEL_LO];

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // decode of a register write to one address, used several times
    function wr_to;
        input en;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_to = en && (addr == target);
        end
    endfunction

    // terminal count of the selected interval, minus one
    // the longest select uses the whole counter and each step down is three
    // bits shorter, so the default width gives 2^17, 2^20, 2^23 and 2^26
    // a narrower counter scales all four alike, which keeps short runs cheap
    // limitation: CNT_W must stay above 9 or the shortest select vanishes
    function [CNT_W-1:0] last_count;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: last_count = {{9{1'b0}}, {(CNT_W-9){1'b1}}};
                2'b01: last_count = {{6{1'b0}}, {(CNT_W-6){1'b1}}};
                2'b10: last_count = {{3{1'b0}}, {(CNT_W-3){1'b1}}};
                default: last_count = {CNT_W{1'b1}};
            endcase
        end
    endfunction

    // ****************************************************************
    // unlock window
    // ****************************************************************
    // window length comes from the shared constants so the unlock tracker
    // and any software timing notes cannot drift apart
    wdta_unlock #(
        .WINDOW(`WDTA_WINDOW_CYCLES)
    ) u_unlock (
        .clock(clock),
        .reset(reset),
        .wr_en(sfr_wr),
        .wr_addr(sfr_addr),
        .wr_data(sfr_wdata),
        .window_open(window_open)
    );

    wire wr_clock_control = wr_to(sfr_wr, sfr_addr, `WDTA_ADDR_CLOCK_CONTROL);
    wire wr_watchdog_control = wr_to(sfr_wr, sfr_addr, `WDTA_ADDR_WATCHDOG_CONTROL);
    wire wr_eie = wr_to(sfr_wr, sfr_addr, `WDTA_ADDR_EXT_IRQ_ENABLE);
    wire wr_ext_irq_flag_reg = wr_to(sfr_wr, sfr_addr, `WDTA_ADDR_EXT_IRQ_FLAG);
    wire wr_rom = wr_to(sfr_wr, sfr_addr, `WDTA_ADDR_ROM_SIZE);
    // protected writes need the window
    wire prot_watchdog_control = wr_watchdog_control && window_open;
    wire wdog_restart = prot_watchdog_control && sfr_wdata[`WDTA_BIT_RESTART];

    // ****************************************************************
    // counter and timeout sequence
    // ****************************************************************
    wire [CNT_W-1:0] term = last_count({timeout_select_hi, timeout_select_lo});
    // compare with >= so a shorter select never lets the count run past
    wire interval_done = (wdog_count >= term);
    wire grace_done = grace_run && (grace_count == GRACE[9:0] - 10'h1);
    wire irq_set = interval_done && !grace_run;

    // counter runs from reset with no enable, on the crystal clock
    // a restart in the very last grace cycle clears the count, but the reset
    // flag and the processor reset still fire: that restart came too late
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wdog_count <= {CNT_W{1'b0}};
            grace_count <= 10'h0;
            grace_run <= 1'b0;
        end else if (wdog_restart) begin
            // restart clears everything, acts only on the write pulse
            wdog_count <= {CNT_W{1'b0}};
            grace_count <= 10'h0;
            grace_run <= 1'b0;
        end else if (grace_done) begin
            // full timeout: start a new interval
            wdog_count <= {CNT_W{1'b0}};
            grace_count <= 10'h0;
            grace_run <= 1'b0;
        end else if (grace_run) begin
            grace_count <= grace_count + 10'h1;
        end else if (interval_done) begin
            grace_run <= 1'b1;
        end else begin
            wdog_count <= wdog_count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************************
    // watchdog control flags
    // ****************************************************************
    // hardware set wins over a software clear in the same cycle
    // so a clear racing a fresh timeout never hides the event from software
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wdog_irq_flag <= 1'b0;
            wdog_reset_flag <= 1'b0;
            wdog_reset_en <= `WDTA_RST_RESET_EN;
            por_flag <= 1'b0;
            pfi_en <= 1'b0;
            pfi_flag <= 1'b0;
        end else begin
            if (irq_set) begin
                wdog_irq_flag <= 1'b1;
            end else if (prot_watchdog_control && !sfr_wdata[`WDTA_BIT_IRQ_FLAG]) begin
                wdog_irq_flag <= 1'b0;
            end
            if (grace_done) begin
                wdog_reset_flag <= 1'b1;
            end else if (wr_watchdog_control && !sfr_wdata[`WDTA_BIT_RESET_FLAG]) begin
                wdog_reset_flag <= 1'b0;
            end
            if (prot_watchdog_control) begin
                wdog_reset_en <= sfr_wdata[`WDTA_BIT_RESET_EN];
            end
            if (sync_por[1]) begin
                por_flag <= 1'b1;
            end else if (prot_watchdog_control && !sfr_wdata[`WDTA_BIT_POR_FLAG]) begin
                por_flag <= 1'b0;
            end
            if (sync_pfi[1]) begin
                pfi_flag <= 1'b1;
            end else if (wr_watchdog_control && !sfr_wdata[`WDTA_BIT_PFI_FLAG]) begin
                pfi_flag <= 1'b0;
            end
            if (wr_watchdog_control) begin
                pfi_en <= sfr_wdata[`WDTA_BIT_PFI_EN];
            end
        end
    end

    // ****************************************************************
    // other registers
    // ****************************************************************
    // external flag inputs cross into the clock domain here
    // select bits are plain storage: a change mid-count is the caller's risk
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            sync_por <= 2'h0;
            sync_pfi <= 2'h0;
            clock_control <= `WDTA_RST_CLOCK_CONTROL;
            extended_interrupt_enable <= `WDTA_RST_EXT_IRQ_ENABLE;
            bg_sel <= 1'b0;
            rom_size <= `WDTA_RST_ROM_SIZE;
        end else begin
            sync_por <= {sync_por[0], por_event};
            sync_pfi <= {sync_pfi[0], pfi_event};
            if (wr_clock_control) begin
                // select changes unprotected; software restarts first
                clock_control <= sfr_wdata;
            end
            if (wr_eie) begin
                extended_interrupt_enable <= sfr_wdata;
            end
            if (wr_ext_irq_flag_reg && window_open) begin
                bg_sel <= sfr_wdata[`WDTA_BIT_BANDGAP];
            end
            if (wr_rom && window_open) begin
                rom_size <= sfr_wdata[2:0];
            end
        end
    end

    // ****************************************************************
    // processor reset pulse
    // ****************************************************************
    // one-cycle reset request on full timeout when enabled
    // registered so the processor sees a clean pulse, never a compare glitch
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_reset <= 1'b0;
        end else begin
            cpu_reset <= grace_done && wdog_reset_en;
        end
    end

    // ****************************************************************
    // interrupt outputs, bandgap and rom size outputs
    // ****************************************************************
    // the flag is set whether or not the enable is on; only the request to
    // the interrupt logic is gated, so polling software still sees it
    wire wdog_irq_en = extended_interrupt_enable[`WDTA_BIT_IRQ_EN];
    // interrupt gated independently of the reset enable
    assign wdog_timeout_irq = wdog_irq_flag && wdog_irq_en;
    assign irq_vector = `WDTA_IRQ_VECTOR;
    assign irq_priority = `WDTA_IRQ_PRIORITY;
    // wake from idle or power management while the irq is pending
    assign wake_request = wdog_timeout_irq && power_saving;
    assign bandgap_select = bg_sel;
    assign rom_size_sel = rom_size;

    // ****************************************************************
    // read mux
    // ****************************************************************
    assign sfr_hit = (sfr_addr == `WDTA_ADDR_CLOCK_CONTROL) ||
                     (sfr_addr == `WDTA_ADDR_WATCHDOG_CONTROL) ||
                     (sfr_addr == `WDTA_ADDR_EXT_IRQ_ENABLE) ||
                     (sfr_addr == `WDTA_ADDR_EXT_IRQ_FLAG) ||
                     (sfr_addr == `WDTA_ADDR_ROM_SIZE);

    // unlock register is write only and reads zero; restart reads zero
    // reserved bit 7 of watchdog control reads zero so masks need not care
    // the mux is combinational: data is valid in the cycle the address stands
    always @* begin
        case (sfr_addr)
            `WDTA_ADDR_CLOCK_CONTROL: sfr_rdata = clock_control;
            `WDTA_ADDR_WATCHDOG_CONTROL: sfr_rdata = {1'b0, por_flag, pfi_en,
                pfi_flag, wdog_irq_flag, wdog_reset_flag, wdog_reset_en, 1'b0};
            `WDTA_ADDR_EXT_IRQ_ENABLE: sfr_rdata = extended_interrupt_enable;
            `WDTA_ADDR_EXT_IRQ_FLAG: sfr_rdata = {7'h00, bg_sel};
            `WDTA_ADDR_ROM_SIZE: sfr_rdata = {5'h00, rom_size};
            default: sfr_rdata = 8'h00;
        endcase
    end

endmodule

// *** sim/wdta_watchdog_chk.sv ***
/* port assertions for the watchdog with timed-access unlock.
   assumes it is bound into wdta_watchdog and sees one clock domain. */
`timescale 1ns/100ps
module wdta_watchdog_chk #(
    parameter GRACE = 512
) (
    input wire clock,
    input wire reset,
    input wire sfr_wr,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire power_saving,
    input wire wdog_timeout_irq,
    input wire [7:0] irq_vector,
    input wire [3:0] irq_priority,
    input wire wake_request,
    input wire cpu_reset
);
    // ********************
    // helper logic
    // ********************
    reg [15:0] irq_age; // cycles the interrupt has stood, saturating so it never wraps
    // age restarts whenever the interrupt is low
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_age <= 16'h0000;
        end else if (!wdog_timeout_irq) begin
            irq_age <= 16'h0000;
        end else if (irq_age != 16'hffff) begin
            irq_age <= irq_age + 16'h0001;
        end
    end
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_vector;
        irq_vector == 8'h63 && irq_priority == 4'hd;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector or priority wrong");
    property p_wake;
        wake_request == (wdog_timeout_irq && power_saving);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request wrong");
    property p_pulse;
        cpu_reset |=> !cpu_reset;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("processor reset longer than one cycle");
    property p_gap;
        cpu_reset && wdog_timeout_irq |-> irq_age == GRACE;
    endproperty
    a_gap: assert property (p_gap)
        else $error("grace period length wrong");
    property p_cpu_en;
        cpu_reset && sfr_addr == 8'hd8 |-> sfr_rdata[2:1] == 2'b11;
    endproperty
    a_cpu_en: assert property (p_cpu_en)
        else $error("processor reset without flag or enable");
    property p_flag;
        wdog_timeout_irq && sfr_addr == 8'hd8 |-> sfr_rdata[3];
    endproperty
    a_flag: assert property (p_flag)
        else $error("interrupt without its flag");
    property p_en;
        wdog_timeout_irq && sfr_addr == 8'he8 |-> sfr_rdata[4];
    endproperty
    a_en: assert property (p_en)
        else $error("interrupt without its enable");
    property p_sticky;
        sfr_addr == 8'hd8 && sfr_rdata[2] && !sfr_wr ##1 sfr_addr == 8'hd8 |-> sfr_rdata[2];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("reset flag cleared without a write");
    property p_restart_bit;
        sfr_addr == 8'hd8 |-> !sfr_rdata[0] && sfr_hit;
    endproperty
    a_restart_bit: assert property (p_restart_bit)
        else $error("restart bit reads back set");
endmodule
bind wdta_watchdog wdta_watchdog_chk #(
    .GRACE(GRACE)
) chk_i (
    .clock(clock),
    .reset(reset),
    .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .power_saving(power_saving),
    .wdog_timeout_irq(wdog_timeout_irq),
    .irq_vector(irq_vector),
    .irq_priority(irq_priority),
    .wake_request(wake_request),
    .cpu_reset(cpu_reset)
);

// *** sim/wdta_watchdog_tb.sv ***
/* self-checking bench for the watchdog with timed-access unlock.
   assumes the checker binds itself; grace and counter width are shortened
   to keep the run brief. */
`timescale 1ns/100ps
module wdta_watchdog_tb;
    localparam GRACE = 8; // short grace period, expectations follow it
    localparam CW = 20; // narrow counter: every interval is 2^6 times shorter
    localparam TERM = 2048; // select 00, 2^(CW-9)
    localparam TERM01 = 16384; // select 01, eight times select 00
    reg clock;
    reg reset;
    reg sfr_wr;
    reg [7:0] sfr_addr;
    reg [7:0] sfr_wdata;
    reg power_saving;
    wire [7:0] sfr_rdata;
    wire sfr_hit;
    wire wdog_timeout_irq;
    wire [7:0] irq_vector;
    wire [3:0] irq_priority;
    wire wake_request;
    wire cpu_reset;
    wire bandgap_select;
    wire [2:0] rom_size_sel;
    integer bad_count;
    integer checked;
    integer n; // cycles since the restart
    integer resets_seen = 0; // processor reset pulses seen
    wdta_watchdog #(.CNT_W(CW), .GRACE(GRACE)) uut (
        .clock(clock),
        .reset(reset),
        .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit),
        .por_event(1'b0),
        .pfi_event(1'b0),
        .power_saving(power_saving),
        .wdog_timeout_irq(wdog_timeout_irq),
        .irq_vector(irq_vector),
        .irq_priority(irq_priority),
        .wake_request(wake_request),
        .cpu_reset(cpu_reset),
        .bandgap_select(bandgap_select),
        .rom_size_sel(rom_size_sel)
    );
    // ********************
    // tasks, entered at a falling edge; chk inside rd runs 2 ns after it
    // ********************
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    // strobe stays high so back-to-back writes never touch it twice
    task wr(input [7:0] a, input [7:0] d);
        begin
            sfr_wr = 1'b1;
            sfr_addr = a;
            sfr_wdata = d;
            @(negedge clock);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            sfr_wr = 1'b0;
            sfr_addr = a;
            #2;
            chk(sfr_rdata, e);
            @(negedge clock);
        end
    endtask
    task idle(input integer c);
        begin
            sfr_wr = 1'b0;
            repeat (c) @(negedge clock);
        end
    endtask
    task unlock;
        begin
            wr(8'hc7, 8'haa);
            wr(8'hc7, 8'h55);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    // ********************
    // clock and watchdog
    // ********************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // count every processor reset pulse over the whole run
    always @(posedge clock) begin
        if (cpu_reset === 1'b1) begin
            resets_seen <= resets_seen + 1;
        end
    end
    // a hang counts as a mismatch
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        final_report;
    end
    // ********************
    // main sequence
    // ********************
    initial begin
        reset = 1'b1;
        sfr_wr = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        power_saving = 1'b0;
        bad_count = 0;
        checked = 0;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        rd(8'h8e, 8'h00);
        rd(8'hd8, 8'h00);
        rd(8'he8, 8'h00);
        rd(8'hc2, 8'h05);
        rd(8'h91, 8'h00);
        rd(8'hc7, 8'h00);
        rd(8'h10, 8'h00);
        chk(sfr_hit, 0);
        chk(irq_vector, 8'h63);
        chk(irq_priority, 4'hd);
        // restart before touching the select field
        unlock;
        wr(8'hd8, 8'h01);
        wr(8'h8e, 8'hc0);
        rd(8'h8e, 8'hc0);
        wr(8'h8e, 8'h00);
        rd(8'h8e, 8'h00);
        // protected bits hold without the unlock, or with it spoiled
        wr(8'hd8, 8'h42);
        rd(8'hd8, 8'h00);
        wr(8'hc2, 8'h00);
        rd(8'hc2, 8'h05);
        wr(8'hc7, 8'haa);
        wr(8'h8e, 8'h00);
        wr(8'hc7, 8'h55);
        wr(8'hd8, 8'h02);
        rd(8'hd8, 8'h00);
        // window edges: fourth cycle refused, third taken
        unlock;
        idle(3);
        wr(8'hd8, 8'h02);
        rd(8'hd8, 8'h00);
        unlock;
        idle(2);
        wr(8'hd8, 8'h02);
        rd(8'hd8, 8'h02);
        unlock;
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h01);
        chk(bandgap_select, 1);
        unlock;
        wr(8'hc2, 8'h03);
        rd(8'hc2, 8'h03);
        chk(rom_size_sel, 3);
        wr(8'he8, 8'h10);
        rd(8'he8, 8'h10);
        // late restart, so a counter that ignores it times out early
        power_saving = 1'b1;
        idle(1500);
        unlock;
        wr(8'hd8, 8'h03);
        sfr_wr = 1'b0;
        sfr_addr = 8'hd8;
        n = 0;
        while (wdog_timeout_irq !== 1'b1 && n < 40000) begin
            @(negedge clock);
            n = n + 1;
        end
        chk(n, TERM);
        chk(sfr_rdata, 8'h0a);
        chk(wake_request, 1);
        while (cpu_reset !== 1'b1 && n < 40000) begin
            @(negedge clock);
            n = n + 1;
        end
        chk(n, TERM + GRACE);
        chk(sfr_rdata, 8'h0e);
        rd(8'he8, 8'h10);
        // flags clear only by a written zero, the interrupt flag only unlocked
        wr(8'hd8, 8'h0a);
        rd(8'hd8, 8'h0a);
        unlock;
        wr(8'hd8, 8'h00);
        rd(8'hd8, 8'h00);
        chk(wdog_timeout_irq, 0);
        // select 01 with the reset disabled: interrupt and reset flag only
        unlock;
        wr(8'hd8, 8'h01);
        wr(8'h8e, 8'h40);
        unlock;
        wr(8'hd8, 8'h01);
        sfr_wr = 1'b0;
        sfr_addr = 8'hd8;
        n = 0;
        while (wdog_timeout_irq !== 1'b1 && n < 40000) begin
            @(negedge clock);
            n = n + 1;
        end
        chk(n, TERM01);
        chk(sfr_rdata, 8'h08);
        idle(GRACE + 4);
        rd(8'hd8, 8'h0c);
        chk(resets_seen, 1);
        final_report;
    end
endmodule
